/* asf_consts.vh */
`ifndef ASF_CONSTS_VH
`define ASF_CONSTS_VH
// register byte addresses (word index times four)
`define ASF_OFF_STATUS      4'h0
`define ASF_OFF_CONTROL     4'h4
`define ASF_OFF_LEVEL       4'h8
// status field positions
`define ASF_BIT_CARRY       0
`define ASF_BIT_ZERO        1
`define ASF_BIT_OVERFLOW    2
`define ASF_BIT_NEGATIVE    3
`define ASF_BIT_REPEAT      4
`define ASF_BIT_PRIO_LO     5
`define ASF_BIT_PRIO_HI     7
`define ASF_BIT_HALF_CARRY  8
// writable status mask (bits 15..9 and repeat bit excluded)
`define ASF_STATUS_WMASK    16'h01EF
`define ASF_STATUS_RESET    16'h0000
// control register bit: nesting disable
`define ASF_BIT_NEST_DIS    0
// priority threshold for the msb
`define ASF_PRIO_LOW_MAX    4'h7
`endif

/* asf_flag_calc.v */
`timescale 1ns/1ps
`include "asf_consts.vh"
module asf_flag_calc #(
  parameter W = 16
) (
  input  wire [W-1:0] i_a,
  input  wire [W-1:0] i_b,
  input  wire         i_sub,
  input  wire         i_byte,
  output wire [W-1:0] o_res,
  output wire         o_carry,
  output wire         o_half,
  output wire         o_neg,
  output wire         o_ovf,
  output wire         o_nz
);
  wire [W-1:0] b_eff;
  wire [W:0]   sum;
  wire [8:0]   sum_b;
  wire [4:0]   nib;
  wire [8:0]   lo8;
  wire         sa;
  wire         sb;
  wire         sr;
  assign b_eff = i_sub ? ~i_b : i_b;
  assign sum   = {1'b0, i_a} + {1'b0, b_eff} + {{W{1'b0}}, i_sub};
  assign sum_b = {1'b0, i_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, i_sub};
  assign nib   = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_sub};
  assign lo8   = sum_b;
  assign o_res = sum[W-1:0];
  // byte ops take flags from bit 7, word ops from bit W-1
  assign sa = i_byte ? i_a[7] : i_a[W-1];
  assign sb = i_byte ? b_eff[7] : b_eff[W-1];
  assign sr = i_byte ? sum_b[7] : sum[W-1];
  // borrow is inverted carry on subtraction
  assign o_carry = (i_byte ? sum_b[8] : sum[W]) ^ i_sub;
  assign o_half  = (i_byte ? nib[4] : lo8[8]) ^ i_sub;
  assign o_neg   = sr;
  assign o_ovf   = (sa == sb) && (sr != sa);
  assign o_nz    = i_byte ? (|sum_b[7:0]) : (|sum[W-1:0]);
endmodule // asf_flag_calc

/* asf_prio_level.v */
`timescale 1ns/1ps
`include "asf_consts.vh"
module asf_prio_level (
  input  wire [2:0] i_low_bits,
  input  wire       i_msb,
  output wire [3:0] o_level,
  output wire       o_msb_status
);
  // msb on top of the three low bits
  assign o_level      = {i_msb, i_low_bits};
  assign o_msb_status = (o_level > `ASF_PRIO_LOW_MAX);
endmodule // asf_prio_level

/* asf_alu_status.v */
`timescale 1ns/1ps
`include "asf_consts.vh"
// Behaviour
// - status bits 15..9 read zero, writes ignored
// - half carry from bit 3 (byte) or bit 7 (word)
// - bits 7..5 hold low three priority bits, 111 masks user interrupts
// - priority bits ignore software writes while nesting disable is one
// - priority msb joins low bits to form a 4-bit level
// - bit 4 shows repeat loop active, hardware only
// - negative flag follows result sign
// - overflow flag set on signed overflow, else cleared
// - zero flag cleared by non-zero result, kept until cleared
// - carry flag set on carry out of result msb
// - on subtraction carry and half carry mean borrow
// - priority msb reads one when level exceeds seven
module asf_alu_status #(
  parameter DATA_W = 16
) (
  input  wire              i_sys_clk,
  input  wire              i_rstn,
  input  wire [3:0]        i_avs_address,
  input  wire              i_avs_read,
  input  wire              i_avs_write,
  input  wire [31:0]       i_avs_writedata,
  input  wire [3:0]        i_avs_byteenable,
  output reg  [31:0]       o_avs_readdata,
  output wire              o_avs_waitrequest,
  input  wire              i_alu_valid,
  input  wire [DATA_W-1:0] i_alu_a,
  input  wire [DATA_W-1:0] i_alu_b,
  input  wire              i_alu_sub,
  input  wire              i_alu_byte,
  input  wire              i_alu_upd_c,
  input  wire              i_alu_upd_dc,
  input  wire              i_alu_upd_n,
  input  wire              i_alu_upd_ov,
  input  wire              i_alu_upd_z,
  input  wire              i_alu_z_sticky,
  input  wire              i_repeat_active,
  input  wire              i_prio_wr,
  input  wire [2:0]        i_prio_low_bits,
  input  wire              i_prio_msb,
  input  wire              i_nesting_disable,
  output reg  [DATA_W-1:0] o_alu_result,
  output wire [15:0]       o_alu_status,
  output wire [3:0]        o_cpu_priority_level,
  output wire              o_priority_level_msb,
  output wire              o_user_irq_masked
);
  reg              carry_r;
  reg              zero_r;
  reg              ovf_r;
  reg              neg_r;
  reg              rpt_r;
  reg  [2:0]       prio_r;
  reg              half_r;
  reg              ack_r;
  reg              nest_sw_r;
  wire [DATA_W-1:0] res;
  wire              f_c;
  wire              f_dc;
  wire              f_n;
  wire              f_ov;
  wire              f_nz;
  wire              nest_dis;
  wire              req;
  wire              wr_stat;
  wire              wr_ctrl;
  wire              lo_en;
  wire              hi_en;
  wire [15:0]       wd;
  wire              hw_z_set;

  asf_flag_calc #(
    .W (DATA_W)
  ) u_calc (
    .i_a     (i_alu_a),
    .i_b     (i_alu_b),
    .i_sub   (i_alu_sub),
    .i_byte  (i_alu_byte),
    .o_res   (res),
    .o_carry (f_c),
    .o_half  (f_dc),
    .o_neg   (f_n),
    .o_ovf   (f_ov),
    .o_nz    (f_nz)
  );

  asf_prio_level u_prio (
    .i_low_bits   (prio_r),
    .i_msb        (i_prio_msb),
    .o_level      (o_cpu_priority_level),
    .o_msb_status (o_priority_level_msb)
  );

  // one wait cycle, answer on the second edge
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_r;
  assign wr_stat = i_avs_write & ack_r & (i_avs_address == `ASF_OFF_STATUS);
  assign wr_ctrl = i_avs_write & ack_r & (i_avs_address == `ASF_OFF_CONTROL);
  assign lo_en   = i_avs_byteenable[0];
  assign hi_en   = i_avs_byteenable[1];
  assign wd      = i_avs_writedata[15:0] & `ASF_STATUS_WMASK;
  assign nest_dis = i_nesting_disable | nest_sw_r;
  assign hw_z_set = ~i_alu_z_sticky;

  assign o_alu_status = {7'h00, half_r, prio_r, rpt_r,
                         neg_r, ovf_r, zero_r, carry_r};
  assign o_user_irq_masked = (prio_r == 3'h7);

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read & ~ack_r) begin
      if (i_avs_address == `ASF_OFF_STATUS) begin
        o_avs_readdata <= {16'h0000, o_alu_status};
      end else if (i_avs_address == `ASF_OFF_CONTROL) begin
        o_avs_readdata <= {31'h0, nest_sw_r};
      end else if (i_avs_address == `ASF_OFF_LEVEL) begin
        o_avs_readdata <= {27'h0, o_priority_level_msb,
                           o_cpu_priority_level};
      end else begin
        o_avs_readdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nest_sw_r <= 1'b0;
    end else if (wr_ctrl & lo_en) begin
      nest_sw_r <= i_avs_writedata[`ASF_BIT_NEST_DIS];
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_alu_result <= {DATA_W{1'b0}};
    end else if (i_alu_valid) begin
      o_alu_result <= res;
    end
  end

  // flags: hardware update first, then software write
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      carry_r <= 1'b0;
      zero_r  <= 1'b0;
      ovf_r   <= 1'b0;
      neg_r   <= 1'b0;
      rpt_r   <= 1'b0;
      prio_r  <= 3'h0;
      half_r  <= 1'b0;
    end else begin
      rpt_r <= i_repeat_active;
      if (i_alu_valid & i_alu_upd_c) begin
        carry_r <= f_c;
      end else if (wr_stat & lo_en) begin
        carry_r <= wd[`ASF_BIT_CARRY];
      end
      if (i_alu_valid & i_alu_upd_z) begin
        if (f_nz) begin
          zero_r <= 1'b0;
        end else if (hw_z_set) begin
          zero_r <= 1'b1;
        end
      end else if (wr_stat & lo_en) begin
        zero_r <= wd[`ASF_BIT_ZERO];
      end
      if (i_alu_valid & i_alu_upd_ov) begin
        ovf_r <= f_ov;
      end else if (wr_stat & lo_en) begin
        ovf_r <= wd[`ASF_BIT_OVERFLOW];
      end
      if (i_alu_valid & i_alu_upd_n) begin
        neg_r <= f_n;
      end else if (wr_stat & lo_en) begin
        neg_r <= wd[`ASF_BIT_NEGATIVE];
      end
      if (i_alu_valid & i_alu_upd_dc) begin
        half_r <= f_dc;
      end else if (wr_stat & hi_en) begin
        half_r <= wd[`ASF_BIT_HALF_CARRY];
      end
      if (i_prio_wr) begin
        prio_r <= i_prio_low_bits;
      end else if (wr_stat & lo_en & ~nest_dis) begin
        prio_r <= wd[`ASF_BIT_PRIO_HI:`ASF_BIT_PRIO_LO];
      end
    end
  end
endmodule // asf_alu_status

/* asf_alu_status_monitor.sv */
`timescale 1ns/1ps
module asf_alu_status_monitor (
  input logic        i_sys_clk, i_rstn, i_avs_write, o_avs_waitrequest, i_alu_valid,
  input logic        i_alu_sub, i_alu_byte, i_alu_upd_c, i_alu_upd_n, i_repeat_active,
  input logic        i_prio_msb, i_nesting_disable, i_prio_wr, o_user_irq_masked,
  input logic        o_priority_level_msb,
  input logic [15:0] i_alu_a, i_alu_b, o_alu_result, o_alu_status,
  input logic [3:0]  o_cpu_priority_level
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire [16:0] sum_w = i_alu_a + i_alu_b;
  wire        word_w = i_alu_valid && !i_alu_byte;
  chk_upper_zero: assert property (o_alu_status[15:9] == 7'h00)
    else $error("upper status bits set");
  chk_repeat_follow: assert property (o_alu_status[4] == $past(i_repeat_active))
    else $error("repeat bit does not follow sequencer");
  chk_level_join: assert property (o_cpu_priority_level == {i_prio_msb, o_alu_status[7:5]})
    else $error("priority level not joined");
  chk_msb_status: assert property (o_priority_level_msb == (o_cpu_priority_level > 4'h7))
    else $error("priority msb status wrong");
  chk_mask_flag: assert property (o_user_irq_masked == (&o_alu_status[7:5]))
    else $error("user mask flag wrong");
  chk_carry_word: assert property (word_w && i_alu_upd_c && !i_alu_sub |=>
    o_alu_status[0] == $past(sum_w[16])) else $error("carry flag wrong");
  chk_neg_sign: assert property (word_w && i_alu_upd_n |=>
    o_alu_status[3] == o_alu_result[15]) else $error("negative flag wrong");
  chk_nest_lock: assert property (i_avs_write && !o_avs_waitrequest && i_nesting_disable
    && !i_prio_wr |=> $stable(o_alu_status[7:5])) else $error("priority bits written");
  cover property (word_w && i_alu_sub);
  cover property (i_avs_write && i_nesting_disable);
  cover property (o_user_irq_masked && i_prio_msb);
endmodule // asf_alu_status_monitor

/* asf_seq_model.sv */
`timescale 1ns/1ps
module asf_seq_model (
  input  logic        i_sys_clk,
  output logic        o_alu_valid, o_alu_sub, o_alu_byte, o_z_sticky, o_repeat, o_prio_wr,
  output logic [15:0] o_alu_a, o_alu_b,
  output logic [4:0]  o_upd,
  output logic [2:0]  o_prio
);
  initial {o_alu_valid, o_alu_sub, o_alu_byte, o_z_sticky, o_repeat, o_prio_wr} = 6'h00;
  initial {o_alu_a, o_alu_b, o_upd, o_prio} = 40'h0;
  // one op, operands scrambled once released
  task automatic op(input logic [15:0] a, b, input logic [2:0] m, input logic [4:0] u);
    o_alu_valid <= 1'b1;
    o_alu_a <= a;
    o_alu_b <= b;
    {o_alu_sub, o_alu_byte, o_z_sticky} <= m;
    o_upd <= u;
    @(posedge i_sys_clk);
    o_alu_valid <= 1'b0;
    o_alu_a <= ~a;
    o_alu_b <= ~b;
    @(posedge i_sys_clk);
  endtask
  task automatic rep(input logic v);
    o_repeat <= v;
    repeat (2) @(posedge i_sys_clk);
  endtask
  task automatic prio(input logic [2:0] v);
    o_prio_wr <= 1'b1;
    o_prio <= v;
    @(posedge i_sys_clk);
    o_prio_wr <= 1'b0;
    o_prio <= ~v;
    @(posedge i_sys_clk);
  endtask
endmodule // asf_seq_model

/* asf_alu_status_tb_top.sv */
`timescale 1ns/1ps
module asf_alu_status_tb_top;
  logic        i_sys_clk = 0, i_rstn = 0, i_avs_read = 0, i_avs_write = 0;
  logic        i_prio_msb = 0, i_nesting_disable = 0;
  logic [3:0]  i_avs_address = 4'h0, i_avs_byteenable = 4'hF, o_cpu_priority_level;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
  logic        o_avs_waitrequest, o_priority_level_msb, o_user_irq_masked;
  logic [15:0] o_alu_result, o_alu_status;
  wire         i_alu_valid, i_alu_sub, i_alu_byte, i_alu_upd_c, i_alu_upd_dc, i_alu_upd_n;
  wire         i_alu_upd_ov, i_alu_upd_z, i_alu_z_sticky, i_repeat_active, i_prio_wr;
  wire  [15:0] i_alu_a, i_alu_b;
  wire  [2:0]  i_prio_low_bits;
  int          mismatches = 0, cmp_count = 0, cyc = 0;
  asf_alu_status i_asf_alu_status (.i_sys_clk, .i_rstn, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_alu_valid, .i_alu_a, .i_alu_b, .i_alu_sub, .i_alu_byte, .i_alu_upd_c, .i_alu_upd_dc,
    .i_alu_upd_n, .i_alu_upd_ov, .i_alu_upd_z, .i_alu_z_sticky, .i_repeat_active, .i_prio_wr,
    .i_prio_low_bits, .i_prio_msb, .i_nesting_disable, .o_alu_result, .o_alu_status,
    .o_cpu_priority_level, .o_priority_level_msb, .o_user_irq_masked);
  asf_seq_model i_asf_seq_model (.i_sys_clk, .o_alu_valid(i_alu_valid), .o_alu_a(i_alu_a),
    .o_alu_b(i_alu_b), .o_alu_sub(i_alu_sub), .o_alu_byte(i_alu_byte),
    .o_z_sticky(i_alu_z_sticky), .o_repeat(i_repeat_active), .o_prio_wr(i_prio_wr),
    .o_upd({i_alu_upd_dc, i_alu_upd_n, i_alu_upd_ov, i_alu_upd_z, i_alu_upd_c}),
    .o_prio(i_prio_low_bits));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (++cyc == 5000) begin
    mismatches++;
    finish_test();
  end
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one avalon access, held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic wt;
    n = 0;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(negedge i_sys_clk);
      wt = (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      @(posedge i_sys_clk);
      n++;
    end while (wt && n < 20);
    if (n >= 20) mismatches++;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    i_avs_writedata <= ~d;
    @(posedge i_sys_clk);
  endtask
  task automatic alu(input logic [15:0] a, b, input logic [2:0] m, input logic [4:0] u,
                     input logic [8:0] e);
    logic [15:0] r;
    r = m[2] ? a - b : a + b;
    i_asf_seq_model.op(a, b, m, u);
    chk("flags", e, o_alu_status & 16'h010F);
    chk("result", r, o_alu_result);
  endtask
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    chk("status_rst", 32'h0, o_alu_status);
    bus(1'b1, 4'h0, 32'hFFFFFFFF);
    bus(1'b0, 4'h0, 32'h0);
    chk("status_rd", 32'h01EF, q);
    chk("masked", 32'h1, o_user_irq_masked);
    i_prio_msb <= 1'b1;
    @(posedge i_sys_clk);
    chk("level", 32'hF, o_cpu_priority_level);
    chk("msb", 32'h1, o_priority_level_msb);
    i_nesting_disable <= 1'b1;
    bus(1'b1, 4'h0, 32'h0);
    chk("nest_lock", 32'h00E0, o_alu_status);
    i_asf_seq_model.prio(3'h2);
    chk("hw_prio", 32'h0040, o_alu_status);
    bus(1'b0, 4'h8, 32'h0);
    chk("level_rd", 32'h1A, q);
    i_nesting_disable <= 1'b0;
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk("ctrl_rd", 32'h1, q);
    bus(1'b1, 4'h0, 32'h0);
    chk("ctrl_lock", 32'h0040, o_alu_status);
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF);
    chk("unmapped_wr", 32'h0040, o_alu_status);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped_rd", 32'h0, q);
    alu(16'h7FFF, 16'h0001, 3'h0, 5'h1F, 9'h10C);
    alu(16'hFFFF, 16'h0001, 3'h0, 5'h1F, 9'h103);
    alu(16'h0000, 16'h0001, 3'h4, 5'h1F, 9'h109);
    alu(16'h8000, 16'h0001, 3'h4, 5'h1F, 9'h104);
    alu(16'h000F, 16'h0001, 3'h2, 5'h1F, 9'h100);
    alu(16'h0080, 16'h0080, 3'h2, 5'h1F, 9'h007);
    alu(16'h0010, 16'h0001, 3'h6, 5'h1F, 9'h100);
    alu(16'h1234, 16'h0000, 3'h0, 5'h1F, 9'h000);
    alu(16'h5555, 16'h5555, 3'h5, 5'h1F, 9'h000);
    alu(16'h0000, 16'h0000, 3'h0, 5'h1F, 9'h002);
    alu(16'h0000, 16'h0000, 3'h1, 5'h1F, 9'h002);
    alu(16'hFFFF, 16'hFFFF, 3'h0, 5'h00, 9'h002);
    i_asf_seq_model.rep(1'b1);
    chk("repeat_on", 32'h1, o_alu_status[4]);
    bus(1'b1, 4'h0, 32'h0);
    chk("repeat_hold", 32'h1, o_alu_status[4]);
    i_asf_seq_model.rep(1'b0);
    chk("repeat_off", 32'h0, o_alu_status[4]);
    i_asf_seq_model.prio(3'h7);
    i_rstn <= 1'b0;
    @(posedge i_sys_clk);
    chk("rst_again", 32'h0, o_alu_status);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    finish_test();
  end
endmodule // asf_alu_status_tb_top
bind asf_alu_status asf_alu_status_monitor i_asf_alu_status_monitor (.i_sys_clk, .i_rstn,
  .i_avs_write, .o_avs_waitrequest, .i_alu_valid, .i_alu_sub, .i_alu_byte, .i_alu_upd_c,
  .i_alu_upd_n, .i_repeat_active, .i_prio_msb, .i_nesting_disable, .i_prio_wr,
  .o_user_irq_masked, .o_priority_level_msb, .i_alu_a, .i_alu_b, .o_alu_result,
  .o_alu_status, .o_cpu_priority_level);
